// >>> hdl/fspe_pkg.sv
// shared constants and types of the flash self-programming enable block
package fspe_pkg;

    // ********************************************
    // register map
    // ********************************************
    localparam logic [31:0] FSPE_ENABLE_ADDR = 32'hffff_fca0;
    localparam logic [31:0] FSPE_UNLOCK_ADDR = 32'hffff_fca8;
    localparam logic [7:0] FSPE_ENABLE_RESET = 8'h00;
    localparam int FSPE_EN_BIT = 0;

    // ********************************************
    // bus encodings
    // ********************************************
    localparam logic [2:0] FSPE_HSIZE_BYTE = 3'h0;
    localparam logic [2:0] FSPE_HSIZE_WORD = 3'h2;
    localparam logic [1:0] FSPE_HTRANS_NONSEQ = 2'h2;
    localparam logic FSPE_HRESP_OKAY = 1'h0;

    // ********************************************
    // relocated vector entry points, byte offsets from ram base
    // ********************************************
    localparam logic [31:0] FSPE_MI_ENTRY = 32'h0000_0000;
    localparam logic [31:0] FSPE_NMI_ENTRY = 32'h0000_0004;

    // ********************************************
    // state encodings
    // ********************************************
    typedef enum logic [1:0] {
        FSPE_SEL_NONE = 2'b00,
        FSPE_SEL_ENABLE = 2'b01,
        FSPE_SEL_UNLOCK = 2'b10
    } fspe_sel_e;

    typedef enum logic [1:0] {
        FSPE_VEC_IDLE = 2'b00,
        FSPE_VEC_RELOC = 2'b01
    } fspe_vec_e;

endpackage

// >>> hdl/fspe_sync3.sv
// three-stage synchroniser for a pin, change accepted when stages two and three agree
`timescale 1ns/100ps
module fspe_sync3 (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } fspe_sync_s;

    fspe_sync_s st;
    fspe_sync_s next_st;

    // s1 feeds only s2, so a metastable s1 never reaches the compare
    always_comb begin
        next_st = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3) begin
            next_st.level = st.s3;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.level;
endmodule // fspe_sync3

// >>> hdl/fspe_ctrl.sv
// flash self-programming enable gate with interrupt vector relocation, ahb-lite slave
`timescale 1ns/100ps
module fspe_ctrl
    import fspe_pkg::*;
#(
    parameter logic [31:0] RAM_BASE = 32'h1000_0000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic flash_mode_pin,
    output logic flash_write_permit,
    input wire logic self_prog_active,
    input wire logic mi_ack,
    input wire logic [15:0] mi_code,
    input wire logic [31:0] mi_flash_vector,
    input wire logic nmi_ack,
    input wire logic [15:0] nmi_code,
    input wire logic [31:0] nmi_flash_vector,
    output logic vector_valid,
    output logic [31:0] vector_addr,
    output logic [31:0] exception_cause_reg
);
    // ********************************************
    // state
    // ********************************************
    typedef struct packed {
        logic dph_valid;
        logic dph_write;
        fspe_sel_e dph_sel;
        logic dph_byte;
        logic en;
        logic armed;
        logic permit;
        fspe_vec_e vstate;
        logic vec_valid;
        logic [31:0] vec_addr;
        logic [31:0] pend_addr;
        logic [31:0] cause;
    } fspe_st_s;

    fspe_st_s st;
    fspe_st_s next_st;
    logic pin_level;
    logic addr_phase;
    logic en_wr;
    logic unlock_wr;

    function automatic fspe_sel_e decode(input logic [31:0] a);
        if (a == FSPE_ENABLE_ADDR) begin
            return FSPE_SEL_ENABLE;
        end else if (a == FSPE_UNLOCK_ADDR) begin
            return FSPE_SEL_UNLOCK;
        end
        return FSPE_SEL_NONE;
    endfunction

    fspe_sync3 u_pin_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin(flash_mode_pin),
        .level(pin_level)
    );

    assign addr_phase = hsel && hready && (htrans == FSPE_HTRANS_NONSEQ);
    assign en_wr = st.dph_valid && st.dph_write && (st.dph_sel == FSPE_SEL_ENABLE);
    assign unlock_wr = st.dph_valid && st.dph_write && st.dph_byte
        && (st.dph_sel == FSPE_SEL_UNLOCK);

    // ********************************************
    // next state
    // ********************************************
    always_comb begin
        next_st = st;
        next_st.vec_valid = 1'b0;
        // address phase capture
        next_st.dph_valid = addr_phase;
        if (addr_phase) begin
            next_st.dph_write = hwrite;
            next_st.dph_sel = decode(haddr);
            next_st.dph_byte = (hsize == FSPE_HSIZE_BYTE);
        end
        // protected write, valid in any operating mode
        if (en_wr) begin
            if (st.armed) begin
                next_st.en = hwdata[FSPE_EN_BIT];
            end
            next_st.armed = 1'b0;
        end else if (unlock_wr) begin
            next_st.armed = 1'b1;
        end else if (st.dph_valid) begin
            // any other access between the two stores breaks the sequence
            next_st.armed = 1'b0;
        end
        // one cycle lag keeps the permit glitch free; nothing else is steered
        next_st.permit = st.en | pin_level;
        // vector handling, non-maskable wins a simultaneous acknowledge
        case (st.vstate)
            FSPE_VEC_IDLE: begin
                if (nmi_ack) begin
                    next_st.cause[31:16] = nmi_code;
                    if (self_prog_active) begin
                        next_st.pend_addr = RAM_BASE + FSPE_NMI_ENTRY;
                        next_st.vstate = FSPE_VEC_RELOC;
                    end else begin
                        next_st.vec_addr = nmi_flash_vector;
                        next_st.vec_valid = 1'b1;
                    end
                end else if (mi_ack) begin
                    next_st.cause[15:0] = mi_code;
                    if (self_prog_active) begin
                        next_st.pend_addr = RAM_BASE + FSPE_MI_ENTRY;
                        next_st.vstate = FSPE_VEC_RELOC;
                    end else begin
                        next_st.vec_addr = mi_flash_vector;
                        next_st.vec_valid = 1'b1;
                    end
                end
            end
            FSPE_VEC_RELOC: begin
                // extra stage for the relocated path; acks here are dropped
                next_st.vec_addr = st.pend_addr;
                next_st.vec_valid = 1'b1;
                next_st.vstate = FSPE_VEC_IDLE;
            end
            default: begin
                next_st.vstate = FSPE_VEC_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
            st.en <= FSPE_ENABLE_RESET[FSPE_EN_BIT];
        end else begin
            st <= next_st;
        end
    end

    // ********************************************
    // outputs
    // ********************************************
    // zero wait states; the unlock register reads as zero
    assign hreadyout = 1'b1;
    assign hresp = FSPE_HRESP_OKAY;
    always_comb begin
        hrdata = 32'h0000_0000;
        if (st.dph_valid && !st.dph_write && st.dph_sel == FSPE_SEL_ENABLE) begin
            hrdata[FSPE_EN_BIT] = st.en;
        end
    end
    assign flash_write_permit = st.permit;
    assign vector_valid = st.vec_valid;
    assign vector_addr = st.vec_addr;
    assign exception_cause_reg = st.cause;

    // ********************************************
    // checks
    // ********************************************
    unarmed_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (en_wr && !st.armed) |=> (st.en == $past(st.en)))
        else $error("enable changed without unlock");

    armed_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (en_wr && st.armed) |=> (st.en == $past(hwdata[0])) && !st.armed)
        else $error("armed enable write not taken");

    unlock_arms_a: assert property (@(posedge hclk) disable iff (!hresetn)
        unlock_wr |=> st.armed)
        else $error("unlock write did not arm");

    other_access_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.dph_valid && !unlock_wr) |=> !st.armed)
        else $error("arm survived another access");

    permit_or_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 flash_write_permit == ($past(st.en) | $past(pin_level)))
        else $error("permit not enable or pin");

    read_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hrdata[31:1] == 31'h0000_0000)
        else $error("upper read bits not zero");

    mi_reloc_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.vstate == FSPE_VEC_IDLE && mi_ack && !nmi_ack && self_prog_active)
        |=> !vector_valid ##1 (vector_valid && vector_addr == RAM_BASE))
        else $error("maskable not relocated");

    nmi_reloc_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.vstate == FSPE_VEC_IDLE && nmi_ack && self_prog_active)
        |=> ##1 (vector_valid && vector_addr == RAM_BASE + 32'h0000_0004))
        else $error("nmi not relocated");

    flash_vec_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.vstate == FSPE_VEC_IDLE && mi_ack && !nmi_ack && !self_prog_active)
        |=> (vector_valid && vector_addr == $past(mi_flash_vector)))
        else $error("normal vector not used");

    cause_rec_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.vstate == FSPE_VEC_IDLE && nmi_ack) |=> exception_cause_reg[31:16] == $past(nmi_code))
        else $error("fatal cause not recorded");

    read_enable_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.dph_valid && !st.dph_write && st.dph_sel == FSPE_SEL_ENABLE)
        |-> (hrdata[0] == st.en))
        else $error("enable bit not read back");

    unlock_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.dph_valid && !st.dph_write && st.dph_sel != FSPE_SEL_ENABLE)
        |-> (hrdata == 32'h0000_0000))
        else $error("unlock or unmapped read not zero");

    read_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !(st.dph_valid && !st.dph_write)
        |-> (hrdata == 32'h0000_0000))
        else $error("read data outside read phase");

    word_unlock_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.dph_valid && st.dph_write && st.dph_sel == FSPE_SEL_UNLOCK && !st.dph_byte)
        |=> !st.armed)
        else $error("word unlock armed the gate");

    enable_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !en_wr
        |=> (st.en == $past(st.en)))
        else $error("enable changed without a write");

    permit_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st.en
        |=> flash_write_permit)
        else $error("enable bit did not permit");

    permit_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
        pin_level
        |=> flash_write_permit)
        else $error("mode pin did not permit");

    permit_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!st.en && !pin_level)
        |=> !flash_write_permit)
        else $error("permit without bit or pin");

    nmi_flash_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.vstate == FSPE_VEC_IDLE && nmi_ack && !self_prog_active)
        |=> (vector_valid && vector_addr == $past(nmi_flash_vector)))
        else $error("nmi normal vector not used");

    nmi_priority_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.vstate == FSPE_VEC_IDLE && nmi_ack && mi_ack && !self_prog_active)
        |=> (vector_addr == $past(nmi_flash_vector)))
        else $error("maskable won over nmi");

    mi_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.vstate == FSPE_VEC_IDLE && mi_ack && !nmi_ack)
        |=> (exception_cause_reg[15:0] == $past(mi_code)))
        else $error("maskable cause not recorded");

    mi_cause_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.vstate == FSPE_VEC_IDLE && nmi_ack)
        |=> (exception_cause_reg[15:0] == $past(exception_cause_reg[15:0])))
        else $error("maskable cause overwritten by nmi");

    reloc_delay_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.vstate == FSPE_VEC_IDLE && (mi_ack || nmi_ack) && self_prog_active)
        |=> !vector_valid)
        else $error("relocated vector came early");

    reloc_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.vstate == FSPE_VEC_RELOC)
        |=> (st.vstate == FSPE_VEC_IDLE && vector_valid))
        else $error("relocated vector not issued");

    bus_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout
        |-> (hresp == FSPE_HRESP_OKAY))
        else $error("bus response not okay");
endmodule // fspe_ctrl

// >>> tb/tb_fspe_ctrl.sv
// self-checking testbench of the flash self-programming enable block
`timescale 1ns/100ps
module tb_fspe_ctrl;
    import fspe_pkg::*;
    // ********************************************
    // signals and design
    // ********************************************
    localparam logic [31:0] RAM_BASE = 32'h2000_0000;
    localparam logic [31:0] EN = FSPE_ENABLE_ADDR;
    localparam logic [31:0] UL = FSPE_UNLOCK_ADDR;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic flash_mode_pin = 1'b0;
    logic self_prog_active = 1'b0;
    logic mi_ack = 1'b0;
    logic nmi_ack = 1'b0;
    logic [15:0] mi_code = 16'h0000;
    logic [15:0] nmi_code = 16'h0000;
    logic [31:0] mi_flash_vector = 32'h0000_0000;
    logic [31:0] nmi_flash_vector = 32'h0000_0000;
    logic hreadyout, hresp, flash_write_permit, vector_valid;
    logic [31:0] hrdata, vector_addr, exception_cause_reg;
    int n_fail = 0;
    int tests_run = 0;

    always #20 hclk = ~hclk;

    // single slave, so its own ready closes the loop
    fspe_ctrl #(.RAM_BASE(RAM_BASE)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .flash_mode_pin(flash_mode_pin), .flash_write_permit(flash_write_permit),
        .self_prog_active(self_prog_active), .mi_ack(mi_ack), .mi_code(mi_code),
        .mi_flash_vector(mi_flash_vector), .nmi_ack(nmi_ack), .nmi_code(nmi_code),
        .nmi_flash_vector(nmi_flash_vector), .vector_valid(vector_valid),
        .vector_addr(vector_addr), .exception_cause_reg(exception_cause_reg));

    // ********************************************
    // shared tasks
    // ********************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test;
        if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // read data is taken at the very edge that samples ready high
    task automatic wait_ready(output logic [31:0] r);
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            r = hrdata;
            i++;
        end while (hreadyout !== 1'b1 && i < 50);
        if (hreadyout !== 1'b1) begin
            n_fail++;
            finish_test();
        end
    endtask

    // entered just after a rising edge; returns at the edge closing the data phase
    task automatic ahb(input logic [31:0] a, input logic w, input logic [2:0] s,
        input logic [31:0] wd, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= FSPE_HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= s;
        wait_ready(r);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready(r);
        chk("response", 32'(hresp), 32'(FSPE_HRESP_OKAY));
    endtask

    task automatic wr(input logic [31:0] a, input logic [2:0] s, input logic [31:0] d);
        logic [31:0] r;
        ahb(a, 1'b1, s, d, r);
    endtask

    task automatic rdchk(input string n, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        ahb(a, 1'b0, FSPE_HSIZE_WORD, 32'h0000_0000, r);
        chk(n, r, exp);
    endtask

    // ********************************************
    // scenarios
    // ********************************************
    task automatic t_protect;
        rdchk("enable after reset", EN, 32'h0000_0000);
        chk("permit after reset", 32'(flash_write_permit), 32'h0000_0000);
        wr(EN, FSPE_HSIZE_BYTE, 32'h0000_0001);
        rdchk("unarmed write", EN, 32'h0000_0000);
        wr(UL, FSPE_HSIZE_BYTE, 32'h0000_00a5);
        wr(EN, FSPE_HSIZE_BYTE, 32'h0000_00ff);
        rdchk("armed write", EN, 32'h0000_0001);
        chk("permit from bit", 32'(flash_write_permit), 32'h0000_0001);
        wr(EN, FSPE_HSIZE_BYTE, 32'h0000_0000);
        rdchk("second write", EN, 32'h0000_0001);
        rdchk("unlock reads", UL, 32'h0000_0000);
        wr(UL, FSPE_HSIZE_WORD, 32'h0000_0000);
        wr(EN, FSPE_HSIZE_BYTE, 32'h0000_0000);
        rdchk("word unlock", EN, 32'h0000_0001);
        wr(UL, FSPE_HSIZE_BYTE, 32'h0000_0000);
        rdchk("between read", EN, 32'h0000_0001);
        wr(EN, FSPE_HSIZE_BYTE, 32'h0000_0000);
        rdchk("disarmed", EN, 32'h0000_0001);
        wr(UL, FSPE_HSIZE_BYTE, 32'h0000_0000);
        wr(EN, FSPE_HSIZE_WORD, 32'hffff_fffe);
        rdchk("word write", EN, 32'h0000_0000);
        rdchk("unmapped", 32'hffff_fcb0, 32'h0000_0000);
    endtask

    task automatic t_pin;
        flash_mode_pin <= 1'b1;
        repeat (8) @(posedge hclk);
        chk("permit pin high", 32'(flash_write_permit), 32'h0000_0001);
        flash_mode_pin <= 1'b0;
        repeat (8) @(posedge hclk);
        chk("permit pin low", 32'(flash_write_permit), 32'h0000_0000);
    endtask

    // one maskable acknowledge, with a non-maskable one beside it when nmi is set; relocation costs one extra cycle
    task automatic vec(input logic nmi, input logic reloc, input logic [15:0] code,
        input logic [31:0] fv, input logic [31:0] exp);
        // no rom correction exists here, so none is active while programming
        self_prog_active <= reloc;
        @(posedge hclk);
        // a maskable ack beside a non-maskable one must lose
        mi_ack <= 1'b1;
        nmi_ack <= nmi;
        mi_code <= code;
        nmi_code <= code;
        mi_flash_vector <= fv;
        nmi_flash_vector <= fv;
        @(posedge hclk);
        mi_ack <= 1'b0;
        nmi_ack <= 1'b0;
        @(negedge hclk);
        chk("valid first", 32'(vector_valid), 32'(!reloc));
        if (reloc) @(negedge hclk);
        chk("valid", 32'(vector_valid), 32'h0000_0001);
        chk("vector", vector_addr, exp);
        chk("cause", 32'(nmi ? exception_cause_reg[31:16] : exception_cause_reg[15:0]),
            32'(code));
        @(negedge hclk);
        chk("valid pulse", 32'(vector_valid), 32'h0000_0000);
        @(posedge hclk);
    endtask

    task automatic t_reset_mid;
        wr(UL, FSPE_HSIZE_BYTE, 32'h0000_0000);
        wr(EN, FSPE_HSIZE_BYTE, 32'h0000_0001);
        rdchk("before reset", EN, 32'h0000_0001);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk("enable after reset", EN, 32'h0000_0000);
        chk("permit after reset", 32'(flash_write_permit), 32'h0000_0000);
    endtask

    // ********************************************
    // main sequence and watchdog
    // ********************************************
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_protect();
        t_pin();
        vec(1'b0, 1'b0, 16'h0011, 32'h0000_0100, 32'h0000_0100);
        vec(1'b0, 1'b1, 16'h0022, 32'h0000_0100, RAM_BASE);
        vec(1'b1, 1'b1, 16'h0033, 32'h0000_0200, RAM_BASE + FSPE_NMI_ENTRY);
        vec(1'b1, 1'b0, 16'h0044, 32'h0000_0200, 32'h0000_0200);
        t_reset_mid();
        finish_test();
    end

    // whole run needs about a hundred cycles; this allows ample margin
    initial begin
        #400000;
        n_fail++;
        finish_test();
    end
endmodule // tb_fspe_ctrl
